// File: hw/isi_interlock.sv
// Purpose: Injection start, stop and interlock logic with imaging-system contacts.
// Assumes: All contact inputs are asynchronous closures, high means closed.
// Notes:   Contact outputs are high while the contact is to be closed.
//
// Summary of operation
// RULE1: Close imaging-trigger contact when X-ray delay expires during an injection.
// RULE2: Reopen imaging-trigger contact as soon as the start switch opens.
// RULE3: External start is a contact closure; closure enables the start circuit.
// RULE4: External contact opening stops injection unless hand switch still held.
// RULE5: With external start closed, releasing hand switch does not stop injection.
// RULE6: Console disable stops an injection whatever the start inputs show.
// RULE7: Ready contact closed while enabled, open while disabled.
// RULE8: Inhibit input blocks external starts; console starts still work.
// RULE9: Running contact closed during an injection, open in standby.
// RULE10: Each detected R-wave gives one 100 ms sync pulse. Code ignores R-waves that rise while a pulse is active.
// RULE11: Insert a start marker into ECG trace when ECG-triggered injection begins.
// RULE12: In multiple-ECG mode also insert a marker where each injection stops.
// RULE13: Synchronise and debounce every contact input before use.
// RULE14: Delay and pulse durations come from parameterised system-clock counters.
`timescale 1ns/1ps
module isi_interlock #(
  parameter int unsigned DEBOUNCE_CYC   = isi_pkg::DEBOUNCE_CYC,
  parameter int unsigned XRAY_DELAY_CYC = isi_pkg::XRAY_DELAY_CYC,
  parameter int unsigned SYNC_PULSE_CYC = isi_pkg::SYNC_PULSE_CYC
) (
  input  wire logic clk,             // System clock, 100 MHz.
  input  wire logic rst,             // Synchronous reset, active high.
  input  wire logic hand_start_in,   // Local hand switch closed.
  input  wire logic ext_start_in,    // External start contact closed.
  input  wire logic inhibit_in,      // External inhibit contact closed.
  input  wire logic disable_in,      // Console disable switch pressed.
  input  wire logic rwave_in,        // R-wave detector level.
  input  wire logic enabled,         // Injector armed, from the console logic.
  input  wire logic ecg_trig_mode,   // Injections are ECG-triggered.
  input  wire logic multi_ecg_mode,  // Multiple-ECG injection mode.
  output logic      imaging_trig_out,// Imaging-trigger contact closed.
  output logic      ready_out,       // Ready contact closed.
  output logic      running_out,     // Running contact closed.
  output logic      rwave_sync_out,  // R-wave synchronisation pulse.
  output logic      marker_start,    // One-cycle request for a start marker.
  output logic      marker_stop      // One-cycle request for a stop marker.
);

  // --------------------------------------------------------------------------
  // Input conditioning
  // --------------------------------------------------------------------------
  logic [isi_pkg::N_CONTACTS-1:0] raw_w;
  logic [isi_pkg::N_CONTACTS-1:0] clean_w;

  assign raw_w[isi_pkg::IDX_HAND]    = hand_start_in;
  assign raw_w[isi_pkg::IDX_EXT]     = ext_start_in;
  assign raw_w[isi_pkg::IDX_INHIBIT] = inhibit_in;
  assign raw_w[isi_pkg::IDX_DISABLE] = disable_in;
  assign raw_w[isi_pkg::IDX_RWAVE]   = rwave_in;

  for (genvar i = 0; i < isi_pkg::N_CONTACTS; i++) begin : g_db
    // The R-wave line is a logic signal and needs only a short settle.
    isi_debounce #(
      .STABLE_CYC ((i == isi_pkg::IDX_RWAVE) ? 2 : DEBOUNCE_CYC)
    ) u_db (
      .clk    (clk),
      .rst    (rst),
      .raw_in (raw_w[i]),
      .clean  (clean_w[i])
    ); // [RULE13]
  end

  wire hand_w    = clean_w[isi_pkg::IDX_HAND];
  wire ext_w     = clean_w[isi_pkg::IDX_EXT];
  wire inhibit_w = clean_w[isi_pkg::IDX_INHIBIT];
  wire disable_w = clean_w[isi_pkg::IDX_DISABLE];
  wire rwave_w   = clean_w[isi_pkg::IDX_RWAVE];

  // --------------------------------------------------------------------------
  // Start and stop decision
  // --------------------------------------------------------------------------
  wire ext_ok_w    = ext_w && !inhibit_w;            // [RULE3] [RULE8]
  wire any_start_w = hand_w || ext_ok_w;             // [RULE4] [RULE5]
  wire stop_w      = disable_w || !any_start_w;      // [RULE6]
  wire go_w        = enabled && !disable_w && any_start_w;

  isi_pkg::isi_state_t state_q;
  isi_pkg::isi_state_t state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      isi_pkg::ISI_IDLE: begin
        if (go_w) begin
          state_d = isi_pkg::ISI_RUNNING;
        end
      end
      isi_pkg::ISI_RUNNING: begin
        if (stop_w || !enabled) begin
          state_d = isi_pkg::ISI_IDLE; // [RULE4] [RULE5] [RULE6]
        end
      end
      default: begin
        state_d = isi_pkg::ISI_IDLE;
      end
    endcase
  end

  wire start_ev_w = (state_q == isi_pkg::ISI_IDLE) && (state_d == isi_pkg::ISI_RUNNING);
  wire stop_ev_w  = (state_q == isi_pkg::ISI_RUNNING) && (state_d == isi_pkg::ISI_IDLE);

  // --------------------------------------------------------------------------
  // X-ray delay timer
  // --------------------------------------------------------------------------
  logic [isi_pkg::CNT_W-1:0] xray_cnt_q;
  logic                      trig_q;
  wire  xray_done_w = (xray_cnt_q >= isi_pkg::CNT_W'(XRAY_DELAY_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= isi_pkg::ISI_IDLE;
      xray_cnt_q <= '0;
      trig_q     <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_d != isi_pkg::ISI_RUNNING || !any_start_w) begin
        xray_cnt_q <= '0;
        trig_q     <= 1'b0;                          // [RULE2]
      end else if (state_q == isi_pkg::ISI_RUNNING && !trig_q) begin
        if (xray_done_w) begin
          trig_q <= 1'b1;                            // [RULE1]
        end else begin
          xray_cnt_q <= xray_cnt_q + 1'b1;           // [RULE14]
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // R-wave sync pulse and ECG markers
  // --------------------------------------------------------------------------
  logic                      rwave_prev_q;
  logic [isi_pkg::CNT_W-1:0] sync_cnt_q;
  logic                      sync_q;
  logic                      mk_start_q;
  logic                      mk_stop_q;
  logic                      ready_q;
  logic                      running_q;
  wire  rwave_rise_w = rwave_w && !rwave_prev_q;
  wire  sync_end_w   = (sync_cnt_q >= isi_pkg::CNT_W'(SYNC_PULSE_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      rwave_prev_q <= 1'b0;
      sync_cnt_q   <= '0;
      sync_q       <= 1'b0;
      mk_start_q   <= 1'b0;
      mk_stop_q    <= 1'b0;
      ready_q      <= 1'b0;
      running_q    <= 1'b0;
    end else begin
      rwave_prev_q <= rwave_w;
      if (rwave_rise_w && !sync_q) begin
        sync_q     <= 1'b1;                          // [RULE10]
        sync_cnt_q <= '0;
      end else if (sync_q) begin
        if (sync_end_w) begin
          sync_q <= 1'b0;                            // [RULE14]
        end else begin
          sync_cnt_q <= sync_cnt_q + 1'b1;
        end
      end
      mk_start_q <= start_ev_w && ecg_trig_mode;     // [RULE11]
      mk_stop_q  <= stop_ev_w && ecg_trig_mode && multi_ecg_mode; // [RULE12]
      ready_q    <= enabled;                         // [RULE7]
      running_q  <= (state_d == isi_pkg::ISI_RUNNING); // [RULE9]
    end
  end

  assign imaging_trig_out = trig_q;
  assign ready_out        = ready_q;
  assign running_out      = running_q;
  assign rwave_sync_out   = sync_q;
  assign marker_start     = mk_start_q;
  assign marker_stop      = mk_stop_q;

endmodule : isi_interlock

// File: hw/isi_pkg.sv
// Purpose: Shared constants for the injector start and interlock block.
// Assumes: 100 MHz system clock.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package isi_pkg;

  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned SYNC_PULSE_MS   = 100;
  localparam int unsigned SYNC_PULSE_CYC  = SYNC_PULSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int unsigned XRAY_DELAY_MS   = 500;
  localparam int unsigned XRAY_DELAY_CYC  = XRAY_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned N_CONTACTS      = 5;

  // Contact input indices.
  localparam int unsigned IDX_HAND    = 0;
  localparam int unsigned IDX_EXT     = 1;
  localparam int unsigned IDX_INHIBIT = 2;
  localparam int unsigned IDX_DISABLE = 3;
  localparam int unsigned IDX_RWAVE   = 4;

  typedef enum logic [1:0] {
    ISI_IDLE    = 2'b00,
    ISI_RUNNING = 2'b01
  } isi_state_t;

endpackage : isi_pkg

// File: hw/isi_debounce.sv
// Purpose: Two-flop synchroniser followed by a stability debouncer.
// Assumes: Raw input is asynchronous to clk.
// Notes:   Output changes only after the input holds steady for STABLE_CYC cycles.
`timescale 1ns/1ps
module isi_debounce #(
  parameter int unsigned STABLE_CYC = 1000
) (
  input  wire logic clk,    // System clock.
  input  wire logic rst,    // Synchronous reset, active high.
  input  wire logic raw_in, // Asynchronous contact level.
  output logic      clean   // Debounced level.
);

  logic        meta_q;
  logic        sync_q;
  logic [31:0] cnt_q;
  logic        clean_q;

  wire         differs  = (sync_q != clean_q);
  wire         settled  = (cnt_q >= 32'(STABLE_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      cnt_q   <= 32'h0;
      clean_q <= 1'b0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      if (!differs) begin
        cnt_q <= 32'h0;
      end else if (settled) begin
        cnt_q   <= 32'h0;
        clean_q <= sync_q;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign clean = clean_q;

endmodule : isi_debounce

// File: test/isi_interlock_properties.sv
// Purpose: Port-level checks for the interlock block.
// Assumes: Short debounce, delay and pulse counts.
// Notes:   Bound to the block from the bench top file.
`timescale 1ns/1ps
module isi_interlock_chk #(
  parameter int unsigned DEBOUNCE_CYC   = 4,
  parameter int unsigned XRAY_DELAY_CYC = 10,
  parameter int unsigned SYNC_PULSE_CYC = 20
) (
  input wire logic clk,              // Clock.
  input wire logic rst,              // Reset.
  input wire logic hand_start_in,    // Hand.
  input wire logic ext_start_in,     // Ext.
  input wire logic inhibit_in,       // Inhibit.
  input wire logic disable_in,       // Disable.
  input wire logic rwave_in,         // R-wave.
  input wire logic enabled,          // Armed.
  input wire logic ecg_trig_mode,    // ECG.
  input wire logic multi_ecg_mode,   // Multi.
  input wire logic imaging_trig_out, // Trigger.
  input wire logic ready_out,        // Ready.
  input wire logic running_out,      // Running.
  input wire logic rwave_sync_out,   // Sync.
  input wire logic marker_start,     // Start mark.
  input wire logic marker_stop       // Stop mark.
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] hi_cnt_q;
  always_ff @(posedge clk) begin
    if (rst || !rwave_sync_out) hi_cnt_q <= 32'h0;
    else hi_cnt_q <= hi_cnt_q + 32'h1;
  end
  sequence s_ext_go; ext_start_in && !inhibit_in && enabled && !disable_in; endsequence
  sequence s_ext_held; s_ext_go [*8] ##1 s_ext_go [*4]; endsequence
  property p_ready; 1 |=> ready_out == $past(enabled); endproperty
  a_ready: assert property (p_ready) else $error("ready does not follow enable");
  property p_ext_start; s_ext_held |-> running_out; endproperty
  a_ext_start: assert property (p_ext_start) else $error("external start not running");
  property p_disable; disable_in [*8] |-> ##[0:6] !running_out; endproperty
  a_disable: assert property (p_disable) else $error("disable did not stop");
  property p_inhibit; (inhibit_in && !hand_start_in) [*8] |-> ##[0:6] !running_out; endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited remote start runs");
  property p_trig_open; (!hand_start_in && (!ext_start_in || inhibit_in)) [*8] |-> ##[0:6] !imaging_trig_out;
  endproperty
  a_trig_open: assert property (p_trig_open) else $error("trigger stays closed");
  property p_trig_delay;
    $rose(imaging_trig_out) |-> $past(running_out, XRAY_DELAY_CYC) && !$past(running_out, XRAY_DELAY_CYC + 1);
  endproperty
  a_trig_delay: assert property (p_trig_delay) else $error("trigger delay wrong");
  property p_sync_len; $fell(rwave_sync_out) |-> hi_cnt_q == SYNC_PULSE_CYC; endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync pulse length wrong");
  property p_mark_start; $rose(running_out) |-> marker_start == $past(ecg_trig_mode); endproperty
  a_mark_start: assert property (p_mark_start) else $error("start marker wrong");
  property p_mark_stop; $fell(running_out) |-> marker_stop == $past(ecg_trig_mode && multi_ecg_mode); endproperty
  a_mark_stop: assert property (p_mark_stop) else $error("stop marker wrong");
endmodule : isi_interlock_chk

// File: test/isi_imaging_model.sv
// Purpose: External imaging system driving the start and inhibit contacts.
// Assumes: Bench requests arrive as levels.
// Notes:   Inhibit follows blk, start follows go while ready_out is closed, one cycle later.
`timescale 1ns/1ps
module isi_imaging_model (
  input wire logic clk,          // Clock.
  input wire logic go,           // Start wanted.
  input wire logic blk,          // Inhibit wanted.
  input wire logic ready_out,    // Injector ready contact.
  output logic     ext_start_in, // Start contact closed.
  output logic     inhibit_in    // Inhibit contact closed.
);
  initial {ext_start_in, inhibit_in} = 2'h0;
  always @(posedge clk) begin
    ext_start_in <= go && ready_out;
    inhibit_in   <= blk;
  end
endmodule : isi_imaging_model

// File: test/isi_interlock_test.sv
// Purpose: Self-checking bench for the interlock block.
// Assumes: Short counts keep each test to a few hundred cycles.
// Notes:   Row bits are hand, go, inhibit, disable, enabled, running.
`timescale 1ns/1ps
module isi_interlock_test;
  localparam int unsigned DB = 4;
  localparam int unsigned XD = 10;
  localparam int unsigned SP = 20;
  logic       clk = 1'b0, rst = 1'b1, hand = 1'b0, go = 1'b0, blk = 1'b0, dis = 1'b0;
  logic       en = 1'b0, rw = 1'b0, ecg = 1'b1, multi = 1'b1;
  logic       ext, inh, trig, rdy, run, sync, mk_s, mk_e;
  logic [4:0] obs;
  logic [5:0] rows [12] = '{6'h23, 6'h33, 6'h13, 6'h1a, 6'h3b, 6'h26, 6'h02, 6'h13, 6'h33, 6'h23, 6'h02, 6'h20};
  int         mismatches = 0, num_checks = 0, n, hi_n = 0;
  assign obs = {sync, mk_e, mk_s, trig, run};
  always #5 clk = ~clk;
  always @(posedge clk) if (sync) hi_n <= hi_n + 1;
  isi_imaging_model i_far (.clk(clk), .go(go), .blk(blk), .ready_out(rdy), .ext_start_in(ext), .inhibit_in(inh));
  isi_interlock #(.DEBOUNCE_CYC(DB), .XRAY_DELAY_CYC(XD), .SYNC_PULSE_CYC(SP)) i_dut (
    .clk(clk), .rst(rst), .hand_start_in(hand), .ext_start_in(ext), .inhibit_in(inh), .disable_in(dis),
    .rwave_in(rw), .enabled(en), .ecg_trig_mode(ecg), .multi_ecg_mode(multi), .imaging_trig_out(trig),
    .ready_out(rdy), .running_out(run), .rwave_sync_out(sync), .marker_start(mk_s), .marker_stop(mk_e));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic wait_bit(input int b, input logic v, output int k);
    k = 0;
    while (obs[b] !== v) begin
      @(posedge clk);
      k++;
      if (k > 60) begin
        mismatches++;
        close_out();
      end
    end
  endtask : wait_bit
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      {hand, go, blk, dis, en} <= rows[i][5:1];
      repeat (30) @(posedge clk);
      check({rdy, trig, run}, {rows[i][1], rows[i][0], rows[i][0]});
    end
    $display("row table done");
    en <= 1'b1;
    wait_bit(0, 1'b1, n);
    check(mk_s, 1'b1);
    wait_bit(1, 1'b1, n);
    check(8'(n), 8'(XD));
    hand <= 1'b0;
    wait_bit(0, 1'b0, n);
    check({mk_e, trig}, 2'h2);
    @(posedge clk);
    check(mk_e, 1'b0);
    $display("marker and delay test done");
    hi_n = 0;
    rw <= 1'b1;
    repeat (3) @(posedge clk);
    rw <= 1'b0;
    repeat (3) @(posedge clk);
    rw <= 1'b1;
    repeat (40) @(posedge clk);
    check(hi_n, 8'(SP));
    $display("sync pulse test done");
    hand <= 1'b1;
    ecg  <= 1'b0;
    wait_bit(0, 1'b1, n);
    check(mk_s, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check({rdy, obs}, 6'h0);
    rst <= 1'b0;
    repeat (2) begin
      @(posedge clk);
      check(obs, 5'h0);
    end
    $display("reset test done");
    close_out();
  end
endmodule : isi_interlock_test
bind isi_interlock isi_interlock_chk #(
  .DEBOUNCE_CYC(DEBOUNCE_CYC), .XRAY_DELAY_CYC(XRAY_DELAY_CYC), .SYNC_PULSE_CYC(SYNC_PULSE_CYC)
) i_chk (.clk(clk), .rst(rst), .hand_start_in(hand_start_in), .ext_start_in(ext_start_in), .inhibit_in(inhibit_in),
  .disable_in(disable_in), .rwave_in(rwave_in), .enabled(enabled), .ecg_trig_mode(ecg_trig_mode),
  .multi_ecg_mode(multi_ecg_mode), .imaging_trig_out(imaging_trig_out), .ready_out(ready_out),
  .running_out(running_out), .rwave_sync_out(rwave_sync_out), .marker_start(marker_start), .marker_stop(marker_stop));
